/* verilog/fan_pkg.sv */
// Shared constants and carrier types for the fan smoothing slice
package fan_pkg;
  // Clock rate and register word layout
  localparam int CLK_KHZ = 10000;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_ENH = 8'h45;
  localparam logic [7:0] IDX_FANCFG = 8'h4a;
  localparam logic [7:0] IDX_DUTY = 8'h4c;
  localparam logic [7:0] IDX_LUT_LO = 8'h50;
  localparam logic [7:0] IDX_LUT_HI = 8'h67;
  localparam int LUT_BYTES = 24;
  localparam int LUT_ENTRIES = 12;
  // Enhanced_fan_config fields
  localparam int ENH_FINE_BIT = 4;
  localparam int ENH_USF_BIT = 3;
  localparam int ENH_RATE_LSB = 1;
  localparam int ENH_SMOOTH_BIT = 0;
  localparam logic [7:0] ENH_RESET = 8'h00;
  localparam logic [7:0] ENH_RW_MASK = 8'h78;
  localparam logic [7:0] ENH_PROT_MASK = 8'h07;
  // Fan_pwm_config fields
  localparam int CFG_PROG_BIT = 5;
  localparam logic [7:0] FANCFG_RESET = 8'h20;
  localparam logic [7:0] FANCFG_RW_MASK = 8'h3f;
  // Duty values
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] COARSE_MASK = 8'hf0;
  // Time per smoothing step in microseconds, then in clock cycles
  localparam int RAMP_US0 = 23000;
  localparam int RAMP_US1 = 46000;
  localparam int RAMP_US2 = 91000;
  localparam int RAMP_US3 = 182000;
  localparam int RAMP_CYC0 = RAMP_US0 * CLK_KHZ / 1000;
  localparam int RAMP_CYC1 = RAMP_US1 * CLK_KHZ / 1000;
  localparam int RAMP_CYC2 = RAMP_US2 * CLK_KHZ / 1000;
  localparam int RAMP_CYC3 = RAMP_US3 * CLK_KHZ / 1000;
  localparam int RAMP_CNT_W = 21;

  // Smoothing controls as held in the enhanced register
  typedef struct packed {
    logic [1:0] rate;
    logic enable;
  } smooth_cfg_t;

  // Limit comparison results
  typedef struct packed {
    logic above_high;
    logic above_crit;
  } limit_status_t;
endpackage

/* verilog/ramp_tick.sv */
// Step period timer for duty smoothing
`timescale 1ns/1ps
module ramp_tick #(
  parameter int CYC0 = fan_pkg::RAMP_CYC0,
  parameter int CYC1 = fan_pkg::RAMP_CYC1,
  parameter int CYC2 = fan_pkg::RAMP_CYC2,
  parameter int CYC3 = fan_pkg::RAMP_CYC3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  input wire logic [1:0] rate,
  output logic tick
);
  import fan_pkg::*;

  logic [RAMP_CNT_W-1:0] cnt_q;
  logic [RAMP_CNT_W-1:0] cnt_d;
  logic [RAMP_CNT_W-1:0] limit;

  // Counter width must hold the longest period
  if (CYC0 < 1 || CYC1 < 1 || CYC2 < 1 || CYC3 < 1 ||
      CYC3 >= (1 << RAMP_CNT_W)) begin : g_chk
    $error("ramp_tick: period out of range");
  end

  // Period per step chosen by the rate code
  assign limit = (rate == 2'b00) ? RAMP_CNT_W'(CYC0 - 1) :
                 (rate == 2'b01) ? RAMP_CNT_W'(CYC1 - 1) :
                 (rate == 2'b10) ? RAMP_CNT_W'(CYC2 - 1) :
                 RAMP_CNT_W'(CYC3 - 1);
  assign tick = run && (cnt_q >= limit);
  // Idle holds the count at zero so a new ramp waits a full period
  assign cnt_d = (!run || tick) ? '0 : cnt_q + 1'b1;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* verilog/pwm_wave.sv */
// Free running PWM waveform from an 8-bit duty
`timescale 1ns/1ps
module pwm_wave (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] duty,
  output logic pwm_q
);
  logic [7:0] phase_q;

  // Output high while phase is below duty; 8'hff is full on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 8'h00;
      pwm_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 8'h01;
      pwm_q <= (duty == 8'hff) || (phase_q < duty);
    end
  end
endmodule

/* verilog/fan_smooth.sv */
// Fan PWM configuration, lookup and smoothing with APB registers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
//
// Contract
// - Fine 1/256 duty steps apply only with fine enable at 22.5 kHz.
// - With the format bit clear, limits compare as signed values.
// - With the format bit set, limits compare as unsigned values.
// - The rate code picks 23, 46, 91 or 182 ms per smoothing step.
// - Rate and smoothing enable are writable only while programming.
// - Smoothing off applies changes at once; on, the duty ramps.
// - Spin-up and a critical override bypass smoothing.
// - Smoothing acts only when the PWM runs at 22.5 kHz.
// - Bits 7:6 of the fan_pwm_config read as zero.
// - Not programming, duty comes from the table and is read-only.
// - Programming, writes set duty directly; it resets to 1.
module fan_smooth #(
  parameter int RAMP_CYC0 = fan_pkg::RAMP_CYC0,
  parameter int RAMP_CYC1 = fan_pkg::RAMP_CYC1,
  parameter int RAMP_CYC2 = fan_pkg::RAMP_CYC2,
  parameter int RAMP_CYC3 = fan_pkg::RAMP_CYC3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [fan_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [fan_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] remote_temp,
  input wire logic [10:0] high_limit,
  input wire logic [10:0] critical_limit,
  input wire logic critical_temp_event,
  input wire logic spinup_active,
  input wire logic freq_22k5,
  output fan_pkg::limit_status_t limit_q,
  output logic [7:0] duty_value,
  output logic pwm_out
);
  import fan_pkg::*;

  // Each step period needs at least one cycle
  if (RAMP_CYC0 < 1 || RAMP_CYC1 < 1 || RAMP_CYC2 < 1 ||
      RAMP_CYC3 < 1) begin : g_chk
    $error("fan_smooth: ramp period below one cycle");
  end

  logic [7:0] enh_q;
  logic [7:0] fancfg_q;
  logic [7:0] duty_q;
  logic [7:0] lut_q [LUT_BYTES];
  limit_status_t limit_d;
  smooth_cfg_t smooth;

  // Highest table entry whose temperature is at or below the reading
  function automatic logic [7:0] lut_lookup(
    input logic [7:0] temp,
    input logic [8*LUT_BYTES-1:0] tbl
  );
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < LUT_ENTRIES; i++) begin
      if (tbl[16*i +: 8] <= temp) begin
        res = tbl[16*i+8 +: 8];
      end
    end
    return res;
  endfunction

  // Limit check in either number format
  function automatic logic above(
    input logic [10:0] t,
    input logic [10:0] lim,
    input logic unsigned_fmt
  );
    above = unsigned_fmt ? (t > lim) : ($signed(t) > $signed(lim));
  endfunction

  // Bus decode; zero wait states, unmapped indexes report an error
  logic [7:0] idx;
  logic hit_enh;
  logic hit_cfg;
  logic hit_duty;
  logic hit_lut;
  logic mapped;
  logic acc;
  logic wr;
  logic prog_en;
  logic [7:0] lut_off;
  logic [7:0] wbyte;
  assign idx = paddr[9:2];
  assign hit_enh = (idx == IDX_ENH);
  assign hit_cfg = (idx == IDX_FANCFG);
  assign hit_duty = (idx == IDX_DUTY);
  assign hit_lut = (idx >= IDX_LUT_LO) && (idx <= IDX_LUT_HI);
  assign mapped = hit_enh || hit_cfg || hit_duty || hit_lut;
  assign acc = psel && penable;
  // Only byte lane 0 carries register data
  assign wr = acc && pwrite && mapped && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign lut_off = idx - IDX_LUT_LO;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prog_en = fancfg_q[CFG_PROG_BIT];

  // Fields steering the duty path
  logic fine_on;
  logic smooth_on;
  logic [7:0] lut_duty;
  logic [7:0] target;
  logic [8*LUT_BYTES-1:0] lut_flat;
  logic tick;
  // One driver for the whole struct keeps lint quiet
  assign smooth = {enh_q[ENH_RATE_LSB +: 2], enh_q[ENH_SMOOTH_BIT]};
  assign fine_on = enh_q[ENH_FINE_BIT] && freq_22k5;
  assign smooth_on = smooth.enable && freq_22k5 && !spinup_active;
  for (genvar g = 0; g < LUT_BYTES; g++) begin : g_flat
    assign lut_flat[8*g +: 8] = lut_q[g];
  end
  assign lut_duty = lut_lookup(remote_temp[10:3], lut_flat);
  assign target = critical_temp_event ? DUTY_FULL : lut_duty;

  // Read mux; reserved bits come back as zero
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit_enh) begin
      rbyte = enh_q;
    end else if (hit_cfg) begin
      rbyte = {2'b00, fancfg_q[5:0]};
    end else if (hit_duty) begin
      rbyte = duty_q;
    end else if (hit_lut) begin
      rbyte = lut_q[lut_off[4:0]];
    end
  end
  assign prdata = {24'h000000, rbyte};

  // Enhanced and fan_pwm_config registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enh_q <= ENH_RESET;
      fancfg_q <= FANCFG_RESET;
    end else if (wr && hit_enh) begin
      enh_q <= (wbyte & ENH_RW_MASK) |
               ((prog_en ? wbyte : enh_q) & ENH_PROT_MASK);
    end else if (wr && hit_cfg) begin
      fancfg_q <= wbyte & FANCFG_RW_MASK;
    end
  end

  // Table storage, writable only while programming
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < LUT_BYTES; i++) begin
        lut_q[i] <= 8'h00;
      end
    end else if (wr && hit_lut && prog_en) begin
      lut_q[lut_off[4:0]] <= wbyte;
    end
  end

  // Step timer runs only while a smoothed move is pending
  logic ramp_run;
  assign ramp_run = smooth_on && !prog_en && !critical_temp_event &&
                    (duty_q != target);
  ramp_tick #(
    .CYC0(RAMP_CYC0),
    .CYC1(RAMP_CYC1),
    .CYC2(RAMP_CYC2),
    .CYC3(RAMP_CYC3)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .run(ramp_run),
    .rate(smooth.rate),
    .tick(tick)
  );

  // Next applied duty; the critical override outranks a software write
  logic [7:0] duty_d;
  always_comb begin
    duty_d = duty_q;
    if (critical_temp_event) begin
      duty_d = DUTY_FULL;
    end else if (prog_en) begin
      if (wr && hit_duty) begin
        duty_d = wbyte;
      end
    end else if (!smooth_on) begin
      duty_d = target;
    end else if (tick) begin
      duty_d = (duty_q < target) ? duty_q + 8'h01 : duty_q - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      duty_q <= DUTY_RESET;
    end else begin
      duty_q <= duty_d;
    end
  end

  // Coarse mode drops the low nibble: 16 steps of 6.25 percent
  logic [7:0] pwm_duty;
  assign pwm_duty = fine_on ? duty_q : (duty_q & COARSE_MASK);
  assign duty_value = duty_q;

  pwm_wave u_pwm (
    .clock(clock),
    .nrst(nrst),
    .duty(pwm_duty),
    .pwm_q(pwm_out)
  );

  // Limit comparisons, registered to keep outputs glitch free
  // signed or unsigned format, chosen by the format bit
  assign limit_d.above_high =
    above(remote_temp, high_limit, enh_q[ENH_USF_BIT]);
  assign limit_d.above_crit =
    above(remote_temp, critical_limit, enh_q[ENH_USF_BIT]);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      limit_q <= '0;
    end else begin
      limit_q <= limit_d;
    end
  end

  // Checks on the duty path and register behaviour
  sequence s_table_mode;
    !prog_en && !critical_temp_event;
  endsequence

  sequence s_locked_enh_write;
    wr && hit_enh && !prog_en;
  endsequence

  AST_CFG_TOP_ZERO: assert property (@(posedge clock) disable iff (!nrst)
    (acc && !pwrite && hit_cfg) |-> prdata[7:6] == 2'b00)
    else $error("fan config top bits not zero");

  AST_RATE_LOCK: assert property (@(posedge clock) disable iff (!nrst)
    s_locked_enh_write |=> $stable(enh_q[2:0]))
    else $error("smoothing bits changed while locked");

  AST_DIRECT_WRITE: assert property (@(posedge clock) disable iff (!nrst)
    (prog_en && wr && hit_duty && !critical_temp_event)
    |=> duty_q == $past(pwdata[7:0]))
    else $error("duty write not applied");

  AST_CRIT_FULL: assert property (@(posedge clock) disable iff (!nrst)
    critical_temp_event |=> duty_q == DUTY_FULL)
    else $error("critical override not at full duty");

  AST_NO_SMOOTH: assert property (@(posedge clock) disable iff (!nrst)
    (s_table_mode and !smooth.enable) |=> duty_q == $past(lut_duty))
    else $error("unsmoothed duty not direct");

  AST_FREQ_GATE: assert property (@(posedge clock) disable iff (!nrst)
    (s_table_mode and !freq_22k5) |=> duty_q == $past(lut_duty))
    else $error("smoothing acted off 22.5 kHz");

  AST_ONE_STEP: assert property (@(posedge clock) disable iff (!nrst)
    (s_table_mode and smooth_on) ##1 !$past(prog_en)
    |-> (duty_q - $past(duty_q) == 8'h01) ||
        ($past(duty_q) - duty_q == 8'h01) || $stable(duty_q))
    else $error("ramp moved more than one step");

  AST_COARSE: assert property (@(posedge clock) disable iff (!nrst)
    !fine_on |-> pwm_duty[3:0] == 4'h0)
    else $error("coarse duty has fine bits");

  AST_LUT_RO: assert property (@(posedge clock) disable iff (!nrst)
    (wr && hit_lut && !prog_en) |=> $stable(lut_flat))
    else $error("table written while read-only");

  AST_SPINUP_DIRECT: assert property (@(posedge clock) disable iff (!nrst)
    (s_table_mode and spinup_active) |=> duty_q == $past(lut_duty))
    else $error("spin-up duty was smoothed");

  // Negative reading never exceeds a non-negative limit when signed
  AST_LIMIT_SIGNED: assert property (@(posedge clock) disable iff (!nrst)
    (!enh_q[ENH_USF_BIT] && remote_temp[10] && !high_limit[10])
    |=> !limit_q.above_high)
    else $error("signed limit compare wrong");

  // Top bit set reads as a large value when unsigned
  AST_LIMIT_UNSIGNED: assert property (@(posedge clock) disable iff (!nrst)
    (enh_q[ENH_USF_BIT] && remote_temp[10] && !high_limit[10])
    |=> limit_q.above_high)
    else $error("unsigned limit compare wrong");
endmodule

/* test/fan_load.sv */
// Fan load model measuring PWM on-time per 256-cycle window
`timescale 1ns/1ps
module fan_load (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pwm,
  output logic [8:0] level
);
  logic [7:0] pos_q;
  logic [8:0] acc_q;
  // Any 256-cycle window of the periodic wave holds duty high cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_q <= 8'h00;
      acc_q <= 9'h000;
      level <= 9'h000;
    end else begin
      pos_q <= pos_q + 8'h01;
      acc_q <= (pos_q == 8'hff) ? 9'h000 : acc_q + {8'h00, pwm};
      if (pos_q == 8'hff) begin
        level <= acc_q + {8'h00, pwm};
      end
    end
  end
endmodule

/* test/tb.sv */
// Self-checking bench for the fan smoothing register slice
`timescale 1ns/1ps
module tb;
  import fan_pkg::*;
  localparam int P0 = 4;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, err, pwm_out;
  logic [10:0] remote_temp = 11'h000;
  logic [10:0] high_limit = 11'h010;
  logic [10:0] critical_limit = 11'h3ff;
  logic critical_temp_event = 1'b0;
  logic spinup_active = 1'b0;
  logic freq_22k5 = 1'b1;
  limit_status_t limit_q;
  logic [7:0] duty_value, rd;
  logic [8:0] level;
  int n_errors = 0;
  int n_checks = 0;
  // Written value beside the value read back
  row_t rows[6] = '{'{IDX_ENH, 8'hff, 8'h7f}, '{IDX_FANCFG, 8'hff, 8'h3f},
    '{IDX_FANCFG, 8'h1f, 8'h1f}, '{IDX_ENH, 8'h00, 8'h07},
    '{IDX_FANCFG, 8'h3f, 8'h3f}, '{IDX_ENH, 8'h00, 8'h00}};

  fan_smooth #(.RAMP_CYC0(P0), .RAMP_CYC1(P0*2), .RAMP_CYC2(P0*4),
    .RAMP_CYC3(P0*8)) DUT (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_temp(remote_temp), .high_limit(high_limit),
    .critical_limit(critical_limit),
    .critical_temp_event(critical_temp_event),
    .spinup_active(spinup_active), .freq_22k5(freq_22k5),
    .limit_q(limit_q), .duty_value(duty_value), .pwm_out(pwm_out));
  fan_load fan (.clock(clock), .nrst(nrst), .pwm(pwm_out), .level(level));

  always #50 clock = ~clock;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    // A wait that runs out counts against the run
    if (n >= 50) n_errors++;
    r = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, rd);
    chk(rd, exp);
  endtask

  // Duty settles one edge after the temperature moves
  task automatic step(input logic [7:0] t, input logic [7:0] exp);
    remote_temp <= {t, 3'b000};
    repeat (2) @(posedge clock);
    chk(duty_value, exp);
  endtask

  // Smoothed move: single steps, p cycles apart
  task automatic ramp(input logic [7:0] t, input logic [7:0] exp,
      input int p);
    int c;
    int last;
    logic [7:0] prev;
    last = -1;
    prev = duty_value;
    remote_temp <= {t, 3'b000};
    for (c = 0; c < 50 * p && duty_value !== exp; c++) begin
      @(posedge clock);
      if (duty_value !== prev) begin
        chk(duty_value, exp > prev ? prev + 1 : prev - 1);
        if (last >= 0) chk(32'(c - last), p);
        last = c;
        prev = duty_value;
      end
    end
    chk(duty_value, exp);
  endtask

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    complete_run;
  end

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rdx(IDX_ENH, 8'h00);
    rdx(IDX_FANCFG, 8'h20);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd, rd);
      rdx(rows[i].idx, rows[i].exp);
    end
    apb(1'b0, 8'h40, 8'h00, rd);
    chk(err, 1'b1);
    // Direct duty write, then output quantisation per mode
    apb(1'b1, IDX_DUTY, 8'h5a, rd);
    // The write lands on the edge the task returns at
    @(posedge clock);
    chk(duty_value, 8'h5a);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, IDX_ENH, k > 0 ? 8'h10 : 8'h00, rd);
      freq_22k5 <= (k < 2);
      repeat (600) @(posedge clock);
      chk(level, k == 1 ? 9'h05a : 9'h050);
    end
    freq_22k5 <= 1'b1;
    // Table: 0 -> 20, 40 -> 23, the rest out of reach
    for (int i = 0; i < LUT_ENTRIES; i++) begin
      apb(1'b1, IDX_LUT_LO + 8'(2 * i), i < 2 ? 8'(i * 64) : 8'hff, rd);
      apb(1'b1, IDX_LUT_LO + 8'(2 * i + 1),
        i == 0 ? 8'h20 : (i == 1 ? 8'h23 : 8'hff), rd);
    end
    apb(1'b1, IDX_FANCFG, 8'h00, rd);
    step(8'h00, 8'h20);
    apb(1'b1, IDX_DUTY, 8'h11, rd);
    apb(1'b1, IDX_LUT_LO + 8'h01, 8'h00, rd);
    rdx(IDX_DUTY, 8'h20);
    step(8'h50, 8'h23);
    step(8'h00, 8'h20);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, IDX_FANCFG, 8'h20, rd);
      apb(1'b1, IDX_ENH, 8'(8'h01 | (r << 1)), rd);
      apb(1'b1, IDX_FANCFG, 8'h00, rd);
      ramp(8'h50, 8'h23, P0 << r);
      ramp(8'h00, 8'h20, P0 << r);
    end
    freq_22k5 <= 1'b0;
    step(8'h50, 8'h23);
    freq_22k5 <= 1'b1;
    spinup_active <= 1'b1;
    step(8'h00, 8'h20);
    spinup_active <= 1'b0;
    critical_temp_event <= 1'b1;
    step(8'h00, 8'hff);
    // Negative reading against positive limits
    remote_temp <= 11'h400;
    repeat (3) @(posedge clock);
    chk(limit_q, 2'b00);
    apb(1'b1, IDX_FANCFG, 8'h20, rd);
    apb(1'b1, IDX_ENH, 8'h08, rd);
    repeat (3) @(posedge clock);
    chk(limit_q, 2'b11);
    // Mid-run reset brings back the power-on values
    nrst <= 1'b0;
    @(posedge clock);
    chk(duty_value, DUTY_RESET);
    nrst <= 1'b1;
    rdx(IDX_FANCFG, FANCFG_RESET);
    rdx(IDX_ENH, ENH_RESET);
    complete_run;
  end
endmodule
